/* File: wdt_pkg.sv */
/*
  Package for the windowed watchdog: register offsets, field positions,
  reset values and timing constants.
  Assumes a single 50 MHz system clock and a slow-clock tick input.
*/
package wdt_pkg;
  localparam logic [3:0] CONTROL_REG_OFFSET = 4'h0;
  localparam logic [3:0] MODE_REG_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_REG_OFFSET = 4'h8;

  localparam logic [7:0] PASSWORD = 8'hA5;
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam int RESTART_BIT = 0;

  localparam int LOAD_LSB = 0;
  localparam int LOAD_MSB = 11;
  localparam int FIEN_BIT = 12;
  localparam int RSTEN_BIT = 13;
  localparam int PROC_BIT = 14;
  localparam int DIS_BIT = 15;
  localparam int DELTA_LSB = 16;
  localparam int DELTA_MSB = 27;
  localparam int DBGHLT_BIT = 28;
  localparam int IDLEHLT_BIT = 29;

  localparam logic [31:0] MODE_RESET = 32'h3FFF2FFF;
  localparam logic [31:0] MODE_WRITABLE = 32'h3FFFFFFF;

  localparam int UNF_BIT = 0;
  localparam int ERR_BIT = 1;

  localparam logic [6:0] PRESCALE_LAST = 7'h7F;
endpackage

/* File: wdt_prescaler.sv */
/*
  Divide-by-128 prescaler on slow-clock ticks for the watchdog.
  Assumes slowTick is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ps
module wdt_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic slowTick,
  output logic tick
);
  logic [6:0] count;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run && slowTick) begin
        count <= count + 7'h01;
        tick <= (count == wdt_pkg::PRESCALE_LAST);
      end
    end
  end
endmodule

/* File: wdt_windowed_watchdog.sv */
/*
  Windowed watchdog timer with a 12-bit down counter and key-protected restart.
  Assumes synchronous bus strobes, a slowTick pulse per slow-clock period,
  and that the reset controller drives rst when it acts on faultOut.
*/
`timescale 1ns/1ps
module wdt_windowed_watchdog (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic slowTick,
  input wire logic debugState,
  input wire logic idleState,
  output logic faultOut,
  output logic faultProcOnly,
  output logic irq
);
  logic [31:0] modeReg;
  logic modeLocked;
  logic [11:0] counter;
  logic underflowFlag;
  logic windowErrorFlag;
  logic prescTick;
  logic run;
  logic keyOk;
  logic restartReq;
  logic modeWrite;
  logic statusRead;
  logic windowBad;
  logic underflowEvt;
  logic [11:0] loadField;
  logic [11:0] deltaField;

  assign loadField = modeReg[wdt_pkg::LOAD_MSB:wdt_pkg::LOAD_LSB];
  assign deltaField = modeReg[wdt_pkg::DELTA_MSB:wdt_pkg::DELTA_LSB];
  function automatic logic hitReg(input logic [3:0] a, input logic [3:0] offset);
    return a == offset;
  endfunction

  // Delta at or above load never errors, since the count never exceeds load.
  function automatic logic outsideWindow(input logic [11:0] count, input logic [11:0] delta,
                                         input logic [11:0] load);
    return (count > delta) && (delta < load);
  endfunction

  assign keyOk = (wdata[wdt_pkg::KEY_MSB:wdt_pkg::KEY_LSB] == wdt_pkg::PASSWORD);
  assign restartReq = wr && hitReg(addr, wdt_pkg::CONTROL_REG_OFFSET) && keyOk
                      && wdata[wdt_pkg::RESTART_BIT];
  assign modeWrite = wr && hitReg(addr, wdt_pkg::MODE_REG_OFFSET) && !modeLocked;
  assign statusRead = rd && hitReg(addr, wdt_pkg::STATUS_REG_OFFSET);
  assign windowBad = restartReq && outsideWindow(counter, deltaField, loadField);
  // Halts apply only when their bit is set; disable freezes the count.
  assign run = !modeReg[wdt_pkg::DIS_BIT]
               && !(debugState && modeReg[wdt_pkg::DBGHLT_BIT])
               && !(idleState && modeReg[wdt_pkg::IDLEHLT_BIT]);
  assign underflowEvt = run && prescTick && (counter == 12'h000)
                        && !restartReq && !modeWrite;

  wdt_prescaler prescaler (
    .clk(clk),
    .rst(rst),
    .clear(restartReq || modeWrite),
    .run(run),
    .slowTick(slowTick),
    .tick(prescTick)
  );

  // Mode register: reset values restore a running watchdog from power-up.
  always_ff @(posedge clk) begin
    if (rst) begin
      modeReg <= wdt_pkg::MODE_RESET;
      modeLocked <= 1'b0;
    end else if (modeWrite) begin
      modeReg <= wdata & wdt_pkg::MODE_WRITABLE;
      modeLocked <= 1'b1;
    end
  end

  // Down counter; a restart outside the window is refused and does not reload the count, which can still step on a prescaler tick.
  always_ff @(posedge clk) begin
    if (rst) begin
      counter <= wdt_pkg::MODE_RESET[wdt_pkg::LOAD_MSB:wdt_pkg::LOAD_LSB];
    end else if (modeWrite) begin
      counter <= wdata[wdt_pkg::LOAD_MSB:wdt_pkg::LOAD_LSB];
    end else if (restartReq && !windowBad) begin
      counter <= loadField;
    end else if (run && prescTick) begin
      if (counter == 12'h000) begin
        counter <= loadField;
      end else begin
        counter <= counter - 12'h001;
      end
    end
  end

  // Sticky flags; a new event in the read cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      underflowFlag <= 1'b0;
      windowErrorFlag <= 1'b0;
    end else begin
      if (underflowEvt) begin
        underflowFlag <= 1'b1;
      end else if (statusRead) begin
        underflowFlag <= 1'b0;
      end
      if (windowBad) begin
        windowErrorFlag <= 1'b1;
      end else if (statusRead) begin
        windowErrorFlag <= 1'b0;
      end
    end
  end

  // Outputs are registered: irq from the next flag values gated by FIEN, faultOut from RSTEN-gated underflow or any window error, faultProcOnly from PROC.
  always_ff @(posedge clk) begin
    if (rst) begin
      faultOut <= 1'b0;
      faultProcOnly <= 1'b0;
      irq <= 1'b0;
    end else begin
      faultOut <= (underflowEvt && modeReg[wdt_pkg::RSTEN_BIT]) || windowBad
                  || (faultOut && !(statusRead && !underflowEvt && !windowBad));
      faultProcOnly <= modeReg[wdt_pkg::PROC_BIT];
      irq <= modeReg[wdt_pkg::FIEN_BIT]
             && (underflowEvt || windowBad
                 || ((underflowFlag || windowErrorFlag) && !statusRead));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      unique case (addr)
        wdt_pkg::MODE_REG_OFFSET: rdata <= modeReg;
        wdt_pkg::STATUS_REG_OFFSET: rdata <= {30'h00000000, windowErrorFlag, underflowFlag};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  chk_restart_reload: assert property (@(posedge clk) disable iff (rst)
    restartReq && !windowBad |=> counter == $past(loadField))
    else $error("restart did not reload counter");

  chk_error_fault: assert property (@(posedge clk) disable iff (rst)
    windowBad |=> windowErrorFlag && faultOut)
    else $error("window error not flagged");

  chk_mode_lock: assert property (@(posedge clk) disable iff (rst)
    modeLocked |=> $stable(modeReg))
    else $error("locked mode register changed");

  chk_bad_key: assert property (@(posedge clk) disable iff (rst)
    wr && addr == wdt_pkg::CONTROL_REG_OFFSET && !keyOk |-> !restartReq)
    else $error("control write taken without key");

  chk_unf_flag: assert property (@(posedge clk) disable iff (rst)
    underflowEvt |=> underflowFlag)
    else $error("underflow not flagged");

  chk_disable_hold: assert property (@(posedge clk) disable iff (rst)
    modeReg[wdt_pkg::DIS_BIT] && !restartReq && !modeWrite |=> $stable(counter))
    else $error("disabled counter moved");

  chk_no_window: assert property (@(posedge clk) disable iff (rst)
    deltaField >= loadField |-> !windowBad)
    else $error("error with window disabled");

  chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
    !$past(modeReg[wdt_pkg::FIEN_BIT]) |-> !irq)
    else $error("interrupt while disabled");

  sequence readClears;
    statusRead && !underflowEvt && !windowBad;
  endsequence
  chk_read_clear: assert property (@(posedge clk) disable iff (rst)
    readClears |=> !underflowFlag && !windowErrorFlag && !faultOut)
    else $error("status read did not clear");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    underflowFlag && !statusRead |=> underflowFlag)
    else $error("flag dropped without read");

  chk_halt_debug: assert property (@(posedge clk) disable iff (rst)
    debugState && modeReg[wdt_pkg::DBGHLT_BIT] && !restartReq && !modeWrite |=> $stable(counter))
    else $error("counter ran in halted debug");

  sequence restartGood;
    restartReq && !windowBad;
  endsequence

  sequence restartBad;
    windowBad && !prescTick;
  endsequence

  chk_mode_reload: assert property (@(posedge clk) disable iff (rst)
    modeWrite
    |=> counter == $past(wdata[wdt_pkg::LOAD_MSB:wdt_pkg::LOAD_LSB]))
    else $error("mode write did not reload counter");

  chk_lock_set: assert property (@(posedge clk) disable iff (rst)
    modeWrite
    |=> modeLocked)
    else $error("mode register not locked after write");

  chk_reset_mode: assert property (@(posedge clk) disable iff (rst)
    $fell(rst)
    |-> modeReg == wdt_pkg::MODE_RESET && !modeLocked)
    else $error("mode register not at reset value");

  chk_reset_count: assert property (@(posedge clk) disable iff (rst)
    $fell(rst)
    |-> counter == wdt_pkg::MODE_RESET[wdt_pkg::LOAD_MSB:wdt_pkg::LOAD_LSB])
    else $error("counter not at reset value");

  chk_reset_quiet: assert property (@(posedge clk) disable iff (rst)
    $fell(rst)
    |-> !faultOut && !irq && !underflowFlag && !windowErrorFlag)
    else $error("flags or outputs survived reset");

  chk_presc_clear: assert property (@(posedge clk) disable iff (rst)
    restartReq || modeWrite
    |=> !prescTick)
    else $error("prescaler not cleared on reload");

  chk_good_reload: assert property (@(posedge clk) disable iff (rst)
    restartGood
    |=> modeLocked == $past(modeLocked))
    else $error("restart touched the mode lock");

  chk_bad_hold: assert property (@(posedge clk) disable iff (rst)
    restartBad
    |=> $stable(counter))
    else $error("refused restart moved the counter");

  chk_window_ok: assert property (@(posedge clk) disable iff (rst)
    restartReq && counter <= deltaField
    |-> !windowBad)
    else $error("restart inside window flagged");

  chk_wide_window: assert property (@(posedge clk) disable iff (rst)
    restartReq && deltaField >= loadField
    |=> counter == $past(loadField))
    else $error("restart refused with window off");

  chk_unf_fault: assert property (@(posedge clk) disable iff (rst)
    underflowEvt && modeReg[wdt_pkg::RSTEN_BIT]
    |=> faultOut)
    else $error("underflow fault not raised");

  chk_no_rsten: assert property (@(posedge clk) disable iff (rst)
    !modeReg[wdt_pkg::RSTEN_BIT] && !windowBad && !faultOut
    |=> !faultOut)
    else $error("fault raised with reset disabled");

  chk_unf_reload: assert property (@(posedge clk) disable iff (rst)
    underflowEvt
    |=> counter == $past(loadField))
    else $error("underflow did not reload counter");

  chk_irq_follow: assert property (@(posedge clk) disable iff (rst)
    modeReg[wdt_pkg::FIEN_BIT] && (underflowFlag || windowErrorFlag) && !statusRead
    |=> irq)
    else $error("pending flag without interrupt");

  chk_err_irq: assert property (@(posedge clk) disable iff (rst)
    windowBad && modeReg[wdt_pkg::FIEN_BIT]
    |=> irq)
    else $error("window error without interrupt");

  chk_unf_irq: assert property (@(posedge clk) disable iff (rst)
    underflowEvt && modeReg[wdt_pkg::FIEN_BIT]
    |=> irq)
    else $error("underflow without interrupt");

  chk_err_sticky: assert property (@(posedge clk) disable iff (rst)
    windowErrorFlag && !statusRead
    |=> windowErrorFlag)
    else $error("error flag dropped without read");

  chk_flag_wins: assert property (@(posedge clk) disable iff (rst)
    underflowEvt && statusRead
    |=> underflowFlag)
    else $error("read clear beat a new underflow");

  chk_dis_no_unf: assert property (@(posedge clk) disable iff (rst)
    modeReg[wdt_pkg::DIS_BIT]
    |-> !underflowEvt)
    else $error("underflow while disabled");

  chk_halt_idle: assert property (@(posedge clk) disable iff (rst)
    idleState && modeReg[wdt_pkg::IDLEHLT_BIT] && !restartReq && !modeWrite
    |=> $stable(counter))
    else $error("counter ran in halted idle");

  chk_halt_presc: assert property (@(posedge clk) disable iff (rst)
    !run
    |=> !prescTick)
    else $error("prescaler ticked while halted");

  chk_run_moves: assert property (@(posedge clk) disable iff (rst)
    run && prescTick && !restartReq && !modeWrite && counter != 12'h000
    |=> counter == $past(counter) - 12'h001)
    else $error("running counter did not step");

  chk_proc_only: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |=> faultProcOnly == $past(modeReg[wdt_pkg::PROC_BIT]))
    else $error("reset kind select not passed on");

  chk_status_data: assert property (@(posedge clk) disable iff (rst)
    statusRead
    |=> rdata == {30'h00000000, $past(windowErrorFlag), $past(underflowFlag)})
    else $error("status read data wrong");

  chk_key_restart: assert property (@(posedge clk) disable iff (rst)
    restartReq
    |-> keyOk)
    else $error("restart taken without key");

  chk_mode_bits: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |-> (modeReg & ~wdt_pkg::MODE_WRITABLE) == 32'h00000000)
    else $error("reserved mode bits set");

  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd
    |=> rdata == 32'h00000000)
    else $error("read data without read strobe");
endmodule

/* File: wdt_reset_ctrl.sv */
/*
  Reset controller model for the watchdog bench.
  Assumes the bench drives porRst and arms fault-driven resets on demand.
*/
`timescale 1ns/1ps
module wdt_reset_ctrl (
  input wire logic clk,
  input wire logic porRst,
  input wire logic armed,
  input wire logic faultIn,
  output logic rst
);
  // Registered so that the fault is answered one edge later, as a real controller would.
  always_ff @(posedge clk) begin
    rst <= porRst | (armed & faultIn);
  end
endmodule

/* File: tb_windowed_watchdog_timer.sv */
/*
  Self-checking bench for the windowed watchdog: register access, window errors, underflow, fault reset.
  Assumes wdt_pkg and the reset controller model are compiled first.
*/
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
  localparam logic [3:0] CR = wdt_pkg::CONTROL_REG_OFFSET;
  localparam logic [3:0] MR = wdt_pkg::MODE_REG_OFFSET;
  localparam logic [3:0] SR = wdt_pkg::STATUS_REG_OFFSET;
  localparam logic [31:0] MODE_A = 32'h00053010;
  localparam logic [31:0] RESTART = {wdt_pkg::PASSWORD, 24'h000001};
  localparam logic [31:0] MODE_H = 32'h30084008;
  logic debugState = 0, idleState = 0;
  logic clk = 0, porRst = 1, rst, wr = 0, rd = 0, slowTick = 0, armed = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [7:0] k;
  logic faultOut, faultProcOnly, irq;
  int mismatches = 0, cmp_count = 0, n;
  always #10 clk = ~clk;
  wdt_reset_ctrl u_wdt_reset_ctrl (.clk(clk), .porRst(porRst), .armed(armed), .faultIn(faultOut), .rst(rst));
  wdt_windowed_watchdog u_wdt_windowed_watchdog (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .slowTick(slowTick), .debugState(debugState), .idleState(idleState), .faultOut(faultOut),
    .faultProcOnly(faultProcOnly), .irq(irq));
  function automatic logic [31:0] exp_sr(input logic u, input logic e);
    return {30'h0, e, u};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    mismatches++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hFC30444A));
    repeat (12) @(posedge clk);
    porRst <= 1'b0;
    repeat (3) @(posedge clk);
    rreg(MR, v);
    chk("mode reset", wdt_pkg::MODE_RESET, v);
    rreg(SR, v);
    chk("status reset", exp_sr(0, 0), v);
    $display("test reset done");
    wreg(MR, MODE_A);
    wreg(MR, 32'h00008FFF);
    rreg(MR, v);
    chk("mode once", MODE_A, v);
    chk("proc only clear", 32'h0, {31'h0, faultProcOnly});
    for (int i = 0; i < 8; i++) begin
      k = 8'($urandom);
      if (k == wdt_pkg::PASSWORD) k = 8'h5A;
      wreg(CR, {k, 23'($urandom), 1'b1});
    end
    rreg(SR, v);
    chk("bad key", exp_sr(0, 0), v);
    $display("test key done");
    // The counter is still at its load value here, which lies above the window.
    wreg(CR, RESTART);
    repeat (3) @(posedge clk);
    #1 chk("irq on error", 32'h1, {31'h0, irq});
    chk("fault on error", 32'h1, {31'h0, faultOut});
    rreg(SR, v);
    chk("status error", exp_sr(0, 1), v);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test window error done");
    slowTick <= 1'b1;
    repeat (1600) @(posedge clk);
    wreg(CR, RESTART);
    rreg(SR, v);
    chk("restart in window", exp_sr(0, 0), v);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    #1 chk("underflow late", 32'h1, {31'h0, n > 2000});
    chk("underflow bound", 32'h1, {31'h0, n < 2300});
    chk("fault on underflow", 32'h1, {31'h0, faultOut});
    rreg(SR, v);
    chk("status underflow", exp_sr(1, 0), v);
    $display("test underflow done");
    armed <= 1'b1;
    wreg(CR, RESTART);
    repeat (6) @(posedge clk);
    armed <= 1'b0;
    repeat (3) @(posedge clk);
    rreg(MR, v);
    chk("mode after fault reset", wdt_pkg::MODE_RESET, v);
    rreg(SR, v);
    chk("status after fault reset", exp_sr(0, 0), v);
    $display("test fault reset done");
    debugState <= 1'b1;
    wreg(MR, MODE_H);
    repeat (1300) @(posedge clk);
    #1 chk("proc only set", 32'h1, {31'h0, faultProcOnly});
    rreg(SR, v);
    chk("debug halt", exp_sr(0, 0), v);
    debugState <= 1'b0;
    idleState <= 1'b1;
    repeat (1300) @(posedge clk);
    rreg(SR, v);
    chk("idle halt", exp_sr(0, 0), v);
    idleState <= 1'b0;
    repeat (1300) @(posedge clk);
    rreg(SR, v);
    chk("halt released", exp_sr(1, 0), v);
    $display("test halt done");
    wrap_up();
  end
endmodule
